// File: verilog/perf_state_status_register.sv
// performance-state status register with msr-style access port
// assumes one request at a time, answered on the following edge
`timescale 1ns/1ps
`default_nettype none
module perf_state_status_register
    import perf_state_pkg::*;
#(
    parameter int CODE_WIDTH = CODE_W
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // msr access port
    input wire logic msr_req_i,
    input wire logic msr_wr_i,
    input wire logic [MSR_ADDR_W-1:0] msr_addr_i,
    input wire logic [MSR_DATA_W-1:0] msr_wdata_i,
    output logic msr_ack_o,
    output logic msr_gp_fault_o,
    output logic [MSR_DATA_W-1:0] msr_rdata_o,
    // advertised capabilities
    input wire logic freq_ctrl_supported_i,
    input wire logic volt_ctrl_supported_i,
    // fused characteristics, static levels
    input wire logic intermediate_state_supported_i,
    input wire logic [ALT_W-1:0] alternate_voltage_offset_i,
    input wire logic voltage_step_size_i,
    input wire logic [CODE_WIDTH-1:0] max_voltage_code_i,
    input wire logic [CODE_WIDTH-1:0] max_ramp_voltage_code_i,
    input wire logic [CODE_WIDTH-1:0] max_frequency_code_i,
    // live operating point, caught as startup after reset release
    input wire logic [CODE_WIDTH-1:0] current_voltage_code_i,
    input wire logic [CODE_WIDTH-1:0] current_frequency_code_i,
    // sequencer side
    input wire logic transition_done_i,
    output logic initiate_change_o,
    output logic [CODE_WIDTH-1:0] requested_frequency_code_o,
    output logic change_pending_o
);
    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    // true for an address this block maps: status or control
    function automatic logic is_mapped(input logic [MSR_ADDR_W-1:0] a);
        return (a == PERF_STATE_STATUS_ADDR) ||
               (a == PERF_STATE_CONTROL_ADDR);
    endfunction

    perf_change_if chg (); // carrier to the tracker

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    logic ack_ff, nxt_ack; // answer strobe
    logic gp_ff, nxt_gp; // fault flag with the answer
    logic [MSR_DATA_W-1:0] rdata_ff, nxt_rdata; // read data
    logic init_ff, nxt_init; // initiate pulse to the sequencer
    logic [CODE_WIDTH-1:0] req_freq_ff, nxt_req_freq; // stored request
    logic pend_ff, nxt_pend; // registered copy of tracker flag
    logic captured_ff, nxt_captured; // startup codes taken
    logic [CODE_WIDTH-1:0] start_volt_ff, nxt_start_volt; // startup vid
    logic [CODE_WIDTH-1:0] start_freq_ff, nxt_start_freq; // startup fid
    logic allowed; // capability gate for any access
    logic ctl_write; // accepted control write
    logic [CODE_WIDTH-1:0] wr_freq; // requested code from the write
    logic [MSR_DATA_W-1:0] status_word; // assembled status

    assign allowed = freq_ctrl_supported_i || volt_ctrl_supported_i; // RQ1
    assign ctl_write = msr_req_i && msr_wr_i && allowed &&
                       (msr_addr_i == PERF_STATE_CONTROL_ADDR);
    assign wr_freq = msr_wdata_i[CTL_REQ_FREQ_LSB +: CODE_WIDTH];

    // tracker handshake; pulse exists only on an accepted write
    assign chg.initiate = ctl_write && msr_wdata_i[CTL_INIT_BIT]; // RQ8
    assign chg.done = transition_done_i; // RQ9

    //--------------------------------------------------------------
    // status word assembly
    //--------------------------------------------------------------
    // every bit not placed below stays zero
    always_comb begin
        status_word = '0; // RQ16
        status_word[INT_SUP_BIT] = intermediate_state_supported_i; // RQ2
        status_word[ALT_OFS_LSB +: ALT_W] = alternate_voltage_offset_i; // RQ3
        status_word[STEP_BIT] = voltage_step_size_i; // RQ4
        status_word[MAX_VOLT_LSB +: CODE_WIDTH] = max_voltage_code_i; // RQ5
        status_word[START_VOLT_LSB +: CODE_WIDTH] = start_volt_ff; // RQ6
        status_word[CUR_VOLT_LSB +: CODE_WIDTH] = current_voltage_code_i; // RQ7
        status_word[PENDING_BIT] = chg.pending; // RQ8
        status_word[RAMP_VOLT_LSB +: CODE_WIDTH] =
            max_ramp_voltage_code_i; // RQ10
        status_word[MAX_FREQ_LSB +: CODE_WIDTH] = max_frequency_code_i; // RQ11
        status_word[START_FREQ_LSB +: CODE_WIDTH] = start_freq_ff; // RQ12
        status_word[CUR_FREQ_LSB +: CODE_WIDTH] =
            current_frequency_code_i; // RQ13
    end

    //--------------------------------------------------------------
    // next values for the access port and stored state
    //--------------------------------------------------------------
    always_comb begin
        nxt_ack = msr_req_i;
        nxt_gp = 1'b0;
        nxt_rdata = '0;
        nxt_init = chg.initiate; // RQ14
        nxt_req_freq = req_freq_ff;
        nxt_pend = chg.pending;
        nxt_captured = 1'b1;
        nxt_start_volt = start_volt_ff;
        nxt_start_freq = start_freq_ff;
        // startup codes are caught on the first edge after release
        if (!captured_ff) begin
            nxt_start_volt = current_voltage_code_i;
            nxt_start_freq = current_frequency_code_i;
        end
        if (msr_req_i) begin
            if (!allowed || !is_mapped(msr_addr_i)) begin
                nxt_gp = 1'b1; // RQ1
            end else if (!msr_wr_i &&
                         (msr_addr_i == PERF_STATE_STATUS_ADDR)) begin
                nxt_rdata = status_word;
            end else if (!msr_wr_i) begin
                // control readback; initiate bit always reads zero
                nxt_rdata[CTL_REQ_FREQ_LSB +: CODE_WIDTH] = req_freq_ff; // RQ14
            end
            // a status write is answered but changes nothing
        end
        if (ctl_write) begin
            if (wr_freq > max_frequency_code_i) begin
                nxt_req_freq = max_frequency_code_i; // RQ15
            end else begin
                nxt_req_freq = wr_freq;
            end
        end
    end

    // register only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            gp_ff <= 1'b0;
            rdata_ff <= '0;
            init_ff <= 1'b0;
            req_freq_ff <= '0;
            pend_ff <= 1'b0;
            captured_ff <= 1'b0;
            start_volt_ff <= '0;
            start_freq_ff <= '0;
        end else begin
            ack_ff <= nxt_ack;
            gp_ff <= nxt_gp;
            rdata_ff <= nxt_rdata;
            init_ff <= nxt_init;
            req_freq_ff <= nxt_req_freq;
            pend_ff <= nxt_pend;
            captured_ff <= nxt_captured;
            start_volt_ff <= nxt_start_volt;
            start_freq_ff <= nxt_start_freq;
        end
    end

    perf_change_tracker u_tracker (
        .core_clk_i (core_clk_i),
        .rst_i (rst_i),
        .chg (chg.tracker)
    );

    // every output straight from a flop
    assign msr_ack_o = ack_ff;
    assign msr_gp_fault_o = gp_ff;
    assign msr_rdata_o = rdata_ff;
    assign initiate_change_o = init_ff;
    assign requested_frequency_code_o = req_freq_ff;
    assign change_pending_o = pend_ff;

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    logic st_rd; // helper: status read this cycle
    assign st_rd = msr_req_i && !msr_wr_i && allowed &&
                   (msr_addr_i == PERF_STATE_STATUS_ADDR);

    AST_GP_NO_CAPS: assert property (@(posedge core_clk_i) // RQ1
        disable iff (rst_i)
        (msr_req_i && !freq_ctrl_supported_i && !volt_ctrl_supported_i)
        |=> (msr_ack_o && msr_gp_fault_o && msr_rdata_o == '0))
        else $error("access without capability did not fault");
    AST_OK_WITH_CAPS: assert property (@(posedge core_clk_i) // RQ1
        disable iff (rst_i)
        st_rd |=> (msr_ack_o && !msr_gp_fault_o))
        else $error("allowed status read faulted");
    AST_FLAG_FIELDS: assert property (@(posedge core_clk_i) // RQ2 RQ3 RQ4
        disable iff (rst_i)
        st_rd |=> (msr_rdata_o[INT_SUP_BIT] ==
                   $past(intermediate_state_supported_i)) &&
                  (msr_rdata_o[ALT_OFS_LSB +: ALT_W] ==
                   $past(alternate_voltage_offset_i)) &&
                  (msr_rdata_o[STEP_BIT] == $past(voltage_step_size_i)))
        else $error("flag fields wrong in status read");
    AST_VOLT_FIELDS: assert property (@(posedge core_clk_i) // RQ5 RQ6 RQ7
        disable iff (rst_i)
        st_rd |=> (msr_rdata_o[MAX_VOLT_LSB +: CODE_WIDTH] ==
                   $past(max_voltage_code_i)) &&
                  (msr_rdata_o[START_VOLT_LSB +: CODE_WIDTH] ==
                   $past(start_volt_ff)) &&
                  (msr_rdata_o[CUR_VOLT_LSB +: CODE_WIDTH] ==
                   $past(current_voltage_code_i)))
        else $error("voltage fields wrong in status read");
    AST_FREQ_FIELDS: assert property (@(posedge core_clk_i) // RQ10 RQ11 RQ12 RQ13
        disable iff (rst_i)
        st_rd |=> (msr_rdata_o[RAMP_VOLT_LSB +: CODE_WIDTH] ==
                   $past(max_ramp_voltage_code_i)) &&
                  (msr_rdata_o[MAX_FREQ_LSB +: CODE_WIDTH] ==
                   $past(max_frequency_code_i)) &&
                  (msr_rdata_o[START_FREQ_LSB +: CODE_WIDTH] ==
                   $past(start_freq_ff)) &&
                  (msr_rdata_o[CUR_FREQ_LSB +: CODE_WIDTH] ==
                   $past(current_frequency_code_i)))
        else $error("frequency fields wrong in status read");
    AST_PENDING_PATH: assert property (@(posedge core_clk_i) // RQ8
        disable iff (rst_i)
        chg.initiate |=> initiate_change_o ##1 change_pending_o)
        else $error("initiate did not reach pending output");
    AST_RSVD_ZERO: assert property (@(posedge core_clk_i) // RQ16
        disable iff (rst_i)
        st_rd |=> ((msr_rdata_o & STATUS_RSVD_MASK) == '0))
        else $error("reserved status bits not zero");
    AST_CLAMP: assert property (@(posedge core_clk_i) // RQ15
        disable iff (rst_i)
        (ctl_write && wr_freq > max_frequency_code_i)
        |=> requested_frequency_code_o == $past(max_frequency_code_i))
        else $error("requested frequency not clamped");
    AST_STATUS_WRITE: assert property (@(posedge core_clk_i) // RQ16
        disable iff (rst_i)
        (msr_req_i && msr_wr_i && msr_addr_i == PERF_STATE_STATUS_ADDR)
        |=> (!initiate_change_o &&
             $stable(requested_frequency_code_o)))
        else $error("status write had an effect");
    // the answer stands one cycle only; a stuck strobe would double-count
    AST_ACK_ONE_CYCLE: assert property (@(posedge core_clk_i) // RQ1
        disable iff (rst_i)
        !msr_req_i |=> (!msr_ack_o && !msr_gp_fault_o && msr_rdata_o == '0))
        else $error("answer stood without a request");
    COV_STATUS_READ: cover property (@(posedge core_clk_i)
        disable iff (rst_i) st_rd ##1 msr_ack_o);
    COV_FAULT: cover property (@(posedge core_clk_i)
        disable iff (rst_i) msr_req_i && !allowed ##1 msr_gp_fault_o);
    COV_CLAMP: cover property (@(posedge core_clk_i)
        disable iff (rst_i) ctl_write && wr_freq > max_frequency_code_i);
endmodule // perf_state_status_register
`default_nettype wire

// File: verilog/perf_state_pkg.sv
// constants for the performance-state status register block
// assumes one core clock domain and a simple msr request port
// Operation
// RQ1 - fault every access without frequency/voltage control
// RQ2 - bit 61 reports intermediate state support
// RQ3 - bits 59-57 report alternate voltage offset
// RQ4 - bit 56 reports voltage step size
// RQ5 - bits 53-48 report max voltage code
// RQ6 - bits 45-40 report startup voltage code
// RQ7 - bits 37-32 report current voltage code
// RQ8 - initiate-change write sets change pending
// RQ9 - transition completion clears change pending
// RQ10 - bits 29-24 report max ramp voltage
// RQ11 - bits 21-16 report max frequency code
// RQ12 - bits 13-8 report startup frequency code
// RQ13 - bits 5-0 report current frequency code
// RQ14 - software writes initiate bit, reads zero
// RQ15 - requested frequency above max clamps to max
// RQ16 - reserved read zero, status writes ignored
package perf_state_pkg;
    //--------------------------------------------------------------
    // widths and addresses
    //--------------------------------------------------------------
    localparam int MSR_ADDR_W = 32;
    localparam int MSR_DATA_W = 64;
    localparam int CODE_W = 6;
    localparam int ALT_W = 3;
    localparam logic [31:0] PERF_STATE_CONTROL_ADDR = 32'hc001_0041;
    localparam logic [31:0] PERF_STATE_STATUS_ADDR = 32'hc001_0042;
    //--------------------------------------------------------------
    // status field positions
    //--------------------------------------------------------------
    localparam int INT_SUP_BIT = 61;
    localparam int ALT_OFS_LSB = 57;
    localparam int STEP_BIT = 56;
    localparam int MAX_VOLT_LSB = 48;
    localparam int START_VOLT_LSB = 40;
    localparam int CUR_VOLT_LSB = 32;
    localparam int PENDING_BIT = 31;
    localparam int RAMP_VOLT_LSB = 24;
    localparam int MAX_FREQ_LSB = 16;
    localparam int START_FREQ_LSB = 8;
    localparam int CUR_FREQ_LSB = 0;
    // reserved bits of the status word, all read as zero
    localparam logic [63:0] STATUS_RSVD_MASK = 64'hd0c0_c0c0_40c0_c0c0;
    //--------------------------------------------------------------
    // control field positions
    //--------------------------------------------------------------
    localparam int CTL_INIT_BIT = 16;
    localparam int CTL_REQ_FREQ_LSB = 0;
    // change tracker states, one-hot
    typedef enum logic [1:0] {
        CHG_IDLE = 2'b01,
        CHG_PENDING = 2'b10
    } chg_state_t;
endpackage

// File: verilog/perf_change_if.sv
// carrier between the register front end and the change tracker
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface perf_change_if;
    logic initiate; // one-cycle pulse, accepted initiate write
    logic done; // one-cycle pulse, transition completed
    logic pending; // level, change in flight
    modport tracker (input initiate, input done, output pending);
    modport owner (output initiate, output done, input pending);
endinterface
`default_nettype wire

// File: verilog/perf_change_tracker.sv
// change-pending tracker for frequency/voltage transitions
// assumes initiate and done are single-cycle pulses on core_clk_i
`timescale 1ns/1ps
`default_nettype none
module perf_change_tracker
    import perf_state_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // link to the register front end
    perf_change_if.tracker chg
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    chg_state_t state_ff; // current tracker state
    chg_state_t nxt_state; // next tracker state

    // next state: a set in the same cycle as a completion wins
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CHG_IDLE: begin
                if (chg.initiate) begin
                    nxt_state = CHG_PENDING; // RQ8
                end
            end
            CHG_PENDING: begin
                // a fresh initiate keeps the flag up, never lost
                if (chg.done && !chg.initiate) begin
                    nxt_state = CHG_IDLE; // RQ9
                end
            end
            default: begin
                nxt_state = CHG_IDLE; // illegal code recovers to idle
            end
        endcase
    end

    // register only
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= CHG_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign chg.pending = (state_ff == CHG_PENDING);

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (rst_i)
        chg.initiate |=> chg.pending) // RQ8
        else $error("initiate did not raise pending");
    AST_DONE_CLEARS: assert property (@(posedge core_clk_i)
        disable iff (rst_i) // RQ9
        (chg.pending && chg.done && !chg.initiate) |=> !chg.pending)
        else $error("completion did not clear pending");
    AST_HOLD_PENDING: assert property (@(posedge core_clk_i)
        disable iff (rst_i) // RQ9
        (chg.pending && !chg.done) |=> chg.pending)
        else $error("pending dropped without completion");
    COV_FULL_CHANGE: cover property (@(posedge core_clk_i) disable iff (rst_i)
        chg.initiate ##1 chg.pending [*2] ##1 chg.done ##1 !chg.pending);
endmodule // perf_change_tracker
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the performance-state status register
// assumes the design answers each msr request one edge after it is taken
`timescale 1ns/1ps
`default_nettype none
module tb;
    import perf_state_pkg::*;
    //--------------------------------------------------------------
    // stimulus and observed signals
    //--------------------------------------------------------------
    typedef struct packed {
        logic isup;
        logic [2:0] alt;
        logic step;
        logic [5:0] maxv, ramp, maxf, curv, curf;
    } row_t;
    logic core_clk_i = 1'b0; // 50 ns clock
    logic rst_i = 1'b1; // held high from time zero
    logic req = 1'b0, wr = 1'b0, done = 1'b0;
    logic [1:0] cap = 2'b11; // frequency, voltage control advertised
    logic [31:0] addr = '0;
    logic [63:0] wd = '0, rd, rdata;
    logic ack, gp, gp_s, init, pend;
    logic [5:0] rqf, sv, sf;
    row_t cfg;
    row_t rows [8];
    logic [5:0] fin [4] = '{6'h3f, 6'h15, 6'h14, 6'h00};
    logic [5:0] fex [4] = '{6'h15, 6'h15, 6'h14, 6'h00};
    int errors = 0;
    int comparisons = 0;
    always #25 core_clk_i = ~core_clk_i;
    // static characteristics come straight from the current row
    perf_state_status_register DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .msr_req_i(req), .msr_wr_i(wr), .msr_addr_i(addr),
        .msr_wdata_i(wd), .msr_ack_o(ack), .msr_gp_fault_o(gp),
        .msr_rdata_o(rdata),
        .freq_ctrl_supported_i(cap[1]), .volt_ctrl_supported_i(cap[0]),
        .intermediate_state_supported_i(cfg.isup),
        .alternate_voltage_offset_i(cfg.alt),
        .voltage_step_size_i(cfg.step),
        .max_voltage_code_i(cfg.maxv),
        .max_ramp_voltage_code_i(cfg.ramp),
        .max_frequency_code_i(cfg.maxf),
        .current_voltage_code_i(cfg.curv),
        .current_frequency_code_i(cfg.curf),
        .transition_done_i(done), .initiate_change_o(init),
        .requested_frequency_code_o(rqf), .change_pending_o(pend));
    //--------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------
    // one comparison, counted; four-state equality so x never matches
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict, reached from the main sequence or the watchdog
    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // expected status word; reserved positions stay zero
    function automatic logic [63:0] word(row_t r, logic p);
        logic [63:0] w;
        w = '0;
        w[61] = r.isup;
        w[59:57] = r.alt;
        w[56] = r.step;
        w[53:48] = r.maxv;
        w[45:40] = sv;
        w[37:32] = r.curv;
        w[31] = p;
        w[29:24] = r.ramp;
        w[21:16] = r.maxf;
        w[13:8] = sf;
        w[5:0] = r.curf;
        return w;
    endfunction
    // one-cycle request, answer sampled once the answering edge settles
    task automatic access(input logic w, input logic [31:0] a,
                          input logic [63:0] d);
        @(posedge core_clk_i);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge core_clk_i);
        req <= 1'b0;
        #1;
        rd = rdata;
        gp_s = gp;
        check("ack", 64'(ack), 64'h1);
    endtask
    // reset for three cycles; startup codes are the codes at release
    task automatic do_reset();
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        sv = cfg.curv;
        sf = cfg.curf;
        @(posedge core_clk_i);
    endtask
    // initiate pulse seen with the answer, pending level one edge later
    task automatic start_change(input logic [5:0] f);
        access(1'b1, PERF_STATE_CONTROL_ADDR, 64'h0000_0000_0001_0000 | 64'(f));
        check("initiate", 64'(init), 64'h1);
    endtask
    //--------------------------------------------------------------
    // watchdog: the whole run needs well under a thousand cycles
    //--------------------------------------------------------------
    initial begin
        #1_000_000;
        errors++;
        end_of_test();
    end
    //--------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------
    initial begin
        rows = '{
            '{1'b0, 3'h0, 1'b0, 6'h3f, 6'h00, 6'h3f, 6'h00, 6'h3f},
            '{1'b1, 3'h1, 1'b1, 6'h00, 6'h3f, 6'h00, 6'h3f, 6'h00},
            '{1'b0, 3'h2, 1'b1, 6'h15, 6'h2a, 6'h15, 6'h2a, 6'h15},
            '{1'b1, 3'h3, 1'b0, 6'h2a, 6'h15, 6'h2a, 6'h15, 6'h2a},
            '{1'b0, 3'h4, 1'b0, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10},
            '{1'b1, 3'h5, 1'b1, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02},
            '{1'b0, 3'h6, 1'b1, 6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h2f},
            '{1'b1, 3'h7, 1'b0, 6'h0f, 6'h30, 6'h33, 6'h0c, 6'h21}};
        cfg = rows[2];
        do_reset();
        // quiet outputs after reset
        #1;
        check("rst out", 64'({ack, gp, init, pend, rqf}), '0);
        check("rst data", rdata, '0);
        // every offset code, fields moving while startup holds still
        foreach (rows[i]) begin
            @(posedge core_clk_i);
            cfg <= rows[i];
            access(1'b0, PERF_STATE_STATUS_ADDR, '0);
            check("status", rd, word(rows[i], 1'b0));
            check("status gp", 64'(gp_s), 64'h0);
        end
        // access allowed with either capability, faults with neither
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            cap <= 2'(k);
            access(1'b0, PERF_STATE_STATUS_ADDR, '0);
            check("cap gp", 64'(gp_s), 64'(k == 0));
            check("cap data", rd, (k == 0) ? '0 : word(rows[7], 1'b0));
        end
        @(posedge core_clk_i);
        cap <= 2'b00;
        access(1'b1, PERF_STATE_CONTROL_ADDR, 64'h0000_0000_0001_0000);
        check("refused gp", 64'(gp_s), 64'h1);
        check("refused init", 64'({init, pend}), '0);
        @(posedge core_clk_i);
        cap <= 2'b11;
        // neighbour address is not mapped
        access(1'b0, 32'hc001_0043, '0);
        check("unmapped gp", 64'(gp_s), 64'h1);
        check("unmapped data", rd, '0);
        // status writes answer without fault and change nothing
        access(1'b1, PERF_STATE_STATUS_ADDR, '1);
        check("wr gp", 64'(gp_s), 64'h0);
        access(1'b0, PERF_STATE_STATUS_ADDR, '0);
        check("after wr", rd, word(rows[7], 1'b0));
        // requested code clamps to the maximum and reads back, written without the initiate bit
        @(posedge core_clk_i);
        cfg <= rows[2];
        foreach (fin[i]) begin
            access(1'b1, PERF_STATE_CONTROL_ADDR, 64'h0000_0000_0000_0000 | 64'(fin[i]));
            check("clamp", 64'(rqf), 64'(fex[i]));
            access(1'b0, PERF_STATE_CONTROL_ADDR, '0);
            check("ctl read", rd, 64'(fex[i]));
        end
        // change: pending set at once, read one idle cycle after the write's answer
        start_change(6'h05);
        access(1'b0, PERF_STATE_STATUS_ADDR, '0);
        check("pend bit", rd, word(rows[2], 1'b1));
        check("pend out", {init, pend}, 2'b01);
        access(1'b0, PERF_STATE_CONTROL_ADDR, '0);
        check("init rd0", rd, 64'h0000_0000_0000_0005);
        // completion pulse clears pending
        @(posedge core_clk_i);
        done <= 1'b1;
        @(posedge core_clk_i);
        done <= 1'b0;
        @(posedge core_clk_i);
        #1;
        check("cleared", 64'(pend), 64'h0);
        access(1'b0, PERF_STATE_STATUS_ADDR, '0);
        check("clr bit", rd, word(rows[2], 1'b0));
        // completion while idle leaves pending low
        @(posedge core_clk_i);
        done <= 1'b1;
        @(posedge core_clk_i);
        done <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        check("idle done", 64'(pend), 64'h0);
        // completion meeting a fresh initiate while pending: the set wins
        start_change(6'h05);
        @(posedge core_clk_i);
        req <= 1'b1;
        wr <= 1'b1;
        addr <= PERF_STATE_CONTROL_ADDR;
        wd <= 64'h0000_0000_0001_0005;
        done <= 1'b1;
        @(posedge core_clk_i);
        req <= 1'b0;
        done <= 1'b0;
        @(posedge core_clk_i);
        #1;
        check("set wins", 64'(pend), 64'h1);
        // reset in the middle of a change drops it
        start_change(6'h3f);
        @(posedge core_clk_i);
        cfg <= rows[5];
        do_reset();
        #1;
        check("mid rst", {pend, init, rqf}, '0);
        access(1'b0, PERF_STATE_STATUS_ADDR, '0);
        check("new start", rd, word(rows[5], 1'b0));
        end_of_test();
    end
endmodule // tb
`default_nettype wire
